// file: logic/nor_loader_map.svh
`ifndef NOR_LOADER_MAP_SVH
`define NOR_LOADER_MAP_SVH

// flash interface geometry
`define FLASH_ADDR_W 26
`define FLASH_DATA_W 16
`define FLASH_ADDR_ZERO 26'h0000000
`define MODE_PARALLEL 2'h0

// timing: system clock and nominal configuration clock
`define MCLK_HZ 50000000
`define CONFIG_CLOCK_OUT_HZ 2000000
`define CONFIG_CLOCK_OUT_HALF_MIN 4

// sync header as seen on the data pins
`define SYNC_HI_BYTE 8'hAA
`define SYNC_LO_BYTE 8'h99
`define SYNC_WORD 16'hAA99

// register byte offsets
`define CTRL_OFS 8'h00
`define LATENCY_OFS 8'h04
`define STATUS_OFS 8'h08
`define ADDR_OFS 8'h0C
`define SAMPLE_OFS 8'h10

// field positions and reset values
`define CTRL_UPSET_BIT 0
`define LATENCY_RESET 8'h08
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// file: logic/nor_loader_pkg.sv
package nor_loader_pkg;

   typedef enum logic [2:0] {
      st_wait_delay,
      st_mode,
      st_latency,
      st_read,
      st_finished,
      st_other
   } load_state_type;

   typedef struct packed {
      logic valid;
      logic wide;
      logic [15:0] data;
   } stream_word_type;

   typedef struct packed {
      logic [2:0] state;
      logic done_pin;
      logic wide;
      logic width_known;
      logic crc_error;
      logic released;
      logic [1:0] mode;
   } status_type;

endpackage : nor_loader_pkg

// file: logic/parallel_nor_config_reader.sv
// How it works
// RQ1: configuration starts by itself after reset, no start command.
// RQ2: a 26-line flash address bus is driven, reaching 1 Gb.
// RQ3: only asynchronous reads: address out, flash returns data.
// RQ4: x8 or x16 width detected from the sync header, not a setting.
// RQ5: data is captured on the rising edge of the configuration clock.
// RQ6: address outputs change on the falling edge of the configuration clock.
// RQ7: address starts at zero, steps by one until completion.
// RQ8: all-ones address wraps to zero and counting continues.
// RQ9: board holds the mode pins at 00 for parallel flash loading.
// RQ10: pull-up control pin 0 enables I/O pull-ups, 1 leaves high impedance. The code turns the pull-ups off after config_complete, even with the pin at 0.
// RQ11: completion pin reads 0 unconfigured, 1 once configured.
// RQ12: delay/error pin low before mode sampling postpones configuration.
// RQ13: after mode sampling the delay/error pin is open-drain, low on CRC error.
// RQ14: with upset detection enabled the delay/error pin stays reserved.
// RQ15: restart pin low resets the whole chip asynchronously.
// RQ16: flash select driven low during configuration, released afterwards.
// RQ17: system may hold restart low until the flash can accept reads.
// RQ18: flash output enable driven low during configuration, released afterwards.
// RQ19: flash write enable driven high during configuration, released afterwards.
// RQ20: address zero held several clock cycles for initial flash latency.
// RQ21: reading stops once the completion pin has gone high.
// RQ22: after the latency, one address step per configuration clock cycle.
`timescale 1ns/1ps
`include "nor_loader_map.svh"
module parallel_nor_config_reader #(
   parameter int CONFIG_CLOCK_OUT_HALF = `MCLK_HZ / (2 * `CONFIG_CLOCK_OUT_HZ)
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic restart_n,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration pins
   input wire logic [1:0] mode_pins,
   input wire logic config_pullup_control,
   input wire logic delay_error_in,
   output logic delay_error_out,
   output logic delay_error_oe,
   input wire logic done_in,
   output logic done_out,
   output logic done_oe,
   output logic config_clock_out,
   // parallel flash
   output logic [`FLASH_ADDR_W-1:0] flash_addr,
   input wire logic [`FLASH_DATA_W-1:0] flash_data_in,
   output logic flash_select_n,
   output logic flash_select_oe,
   output logic flash_output_enable_n,
   output logic flash_output_enable_oe,
   output logic flash_write_enable_n,
   output logic flash_write_enable_oe,
   // chip-side links
   input wire logic config_complete,
   input wire logic crc_error,
   output nor_loader_pkg::stream_word_type stream_word,
   output logic io_pullup_enable,
   output logic delay_pin_user_release
);
   if (CONFIG_CLOCK_OUT_HALF < `CONFIG_CLOCK_OUT_HALF_MIN || CONFIG_CLOCK_OUT_HALF > 255) begin : g_half_check
      $error("CONFIG_CLOCK_OUT_HALF out of range");
   end

   // reset: asserts at once, releases on the clock so no flop sees a runt
   logic chip_reset;
   logic [1:0] rst_rel_reg;
   logic rst;

   // RQ15 async restart
   assign chip_reset = reset | ~restart_n;

   always_ff @(posedge mclk or posedge chip_reset) begin
      if (chip_reset) begin
         rst_rel_reg <= 2'h3;
      end else if (clk_en) begin
         rst_rel_reg <= {rst_rel_reg[0], 1'b0};
      end
   end
   assign rst = rst_rel_reg[1];

   // pin inputs through two flip-flops
   logic [20:0] pins_raw;
   logic [20:0] pins_s;
   logic delay_s;
   logic done_s;
   logic pullup_s;
   logic [1:0] mode_s;
   logic [15:0] data_s;

   assign pins_raw = {delay_error_in, done_in, config_pullup_control, mode_pins, flash_data_in};

   pin_sync #(.WIDTH(21)) pin_sync_i (
      .mclk(mclk),
      .reset(rst),
      .clk_en(clk_en),
      .d(pins_raw),
      .q(pins_s)
   );

   assign delay_s = pins_s[20];
   assign done_s = pins_s[19];
   assign pullup_s = pins_s[18];
   assign mode_s = pins_s[17:16];
   assign data_s = pins_s[15:0];

   // state
   nor_loader_pkg::load_state_type state_reg;
   nor_loader_pkg::load_state_type state_next;
   logic [7:0] div_cnt_reg;
   logic [7:0] lat_cnt_reg;
   logic [7:0] latency_reg;
   logic upset_en_reg;
   logic [1:0] mode_reg;
   logic mode_sampled_reg;
   logic released_reg;
   logic crc_err_reg;
   logic width_known_reg;
   logic wide_reg;
   logic [15:0] sample_reg;
   logic [15:0] prev_sample_reg;

   logic running;
   logic tick;
   logic rise_evt;
   logic fall_evt;
   logic lat_over;
   logic sync8_hit;
   logic sync16_hit;

   assign running = (state_reg == nor_loader_pkg::st_latency) ||
                    (state_reg == nor_loader_pkg::st_read);
   assign tick = running && (div_cnt_reg == 8'(CONFIG_CLOCK_OUT_HALF - 1));
   assign rise_evt = tick && !config_clock_out;
   assign fall_evt = tick && config_clock_out;
   // a zero latency setting still gives one latency cycle, so address zero is held for two clock cycles
   assign lat_over = (lat_cnt_reg + 8'h01) >= latency_reg;
   // RQ4 width detect
   assign sync16_hit = data_s == `SYNC_WORD;
   assign sync8_hit = (prev_sample_reg[7:0] == `SYNC_HI_BYTE) && (data_s[7:0] == `SYNC_LO_BYTE);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         // RQ1 self start
         // RQ12 delay honoured
         nor_loader_pkg::st_wait_delay: begin
            if (delay_s) begin
               state_next = nor_loader_pkg::st_mode;
            end
         end
         // RQ9 mode check
         nor_loader_pkg::st_mode: begin
            if (mode_s == `MODE_PARALLEL) begin
               state_next = nor_loader_pkg::st_latency;
            end else begin
               state_next = nor_loader_pkg::st_other;
            end
         end
         // RQ20 latency hold
         nor_loader_pkg::st_latency: begin
            if (fall_evt && lat_over) begin
               state_next = nor_loader_pkg::st_read;
            end
         end
         // RQ21 stop on done
         nor_loader_pkg::st_read: begin
            if (done_s) begin
               state_next = nor_loader_pkg::st_finished;
            end
         end
         nor_loader_pkg::st_finished: state_next = nor_loader_pkg::st_finished;
         nor_loader_pkg::st_other: state_next = nor_loader_pkg::st_other;
         default: state_next = nor_loader_pkg::st_wait_delay;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= nor_loader_pkg::st_wait_delay;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // RQ5 rising sample
   // RQ6 falling address
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt_reg <= 8'h00;
         config_clock_out <= 1'b0;
      end else if (clk_en) begin
         if (!running) begin
            div_cnt_reg <= 8'h00;
            config_clock_out <= 1'b0;
         end else if (tick) begin
            div_cnt_reg <= 8'h00;
            config_clock_out <= !config_clock_out;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
         end
      end
   end

   // RQ2 26-line address bus
   // RQ7 count from zero
   // RQ8 wraps at all-ones
   // RQ22 one step per cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_addr <= `FLASH_ADDR_ZERO;
         lat_cnt_reg <= 8'h00;
      end else if (clk_en) begin
         if (state_reg == nor_loader_pkg::st_latency && fall_evt) begin
            lat_cnt_reg <= lat_cnt_reg + 8'h01;
         end
         if (state_reg == nor_loader_pkg::st_read && fall_evt && !done_s) begin
            flash_addr <= flash_addr + `FLASH_ADDR_W'(1);
         end
      end
   end

   // RQ3 async read data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sample_reg <= 16'h0000;
         prev_sample_reg <= 16'h0000;
         width_known_reg <= 1'b0;
         wide_reg <= 1'b0;
         stream_word <= '0;
      end else if (clk_en) begin
         stream_word.valid <= 1'b0;
         if (state_reg == nor_loader_pkg::st_read && rise_evt && !done_s) begin
            sample_reg <= data_s;
            prev_sample_reg <= data_s;
            if (!width_known_reg) begin
               // the header word itself is consumed by detection
               if (sync16_hit) begin
                  width_known_reg <= 1'b1;
                  wide_reg <= 1'b1;
               end else if (sync8_hit) begin
                  width_known_reg <= 1'b1;
                  wide_reg <= 1'b0;
               end
            end else begin
               stream_word.valid <= 1'b1;
               stream_word.wide <= wide_reg;
               stream_word.data <= wide_reg ? data_s : {8'h00, data_s[7:0]};
            end
         end
      end
   end

   // RQ11 done pin
   // RQ13 crc flag drive
   // RQ16 select strobe
   // RQ18 output enable
   // RQ19 write enable
   logic cfg_active;
   assign cfg_active = running;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_reg <= 2'h0;
         mode_sampled_reg <= 1'b0;
         released_reg <= 1'b0;
         crc_err_reg <= 1'b0;
         done_out <= 1'b0;
         done_oe <= 1'b1;
         delay_error_out <= 1'b0;
         delay_error_oe <= 1'b0;
         flash_select_n <= 1'b1;
         flash_select_oe <= 1'b0;
         flash_output_enable_n <= 1'b1;
         flash_output_enable_oe <= 1'b0;
         flash_write_enable_n <= 1'b1;
         flash_write_enable_oe <= 1'b0;
         io_pullup_enable <= 1'b0;
         delay_pin_user_release <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == nor_loader_pkg::st_mode) begin
            mode_reg <= mode_s;
            mode_sampled_reg <= 1'b1;
         end
         if (config_complete) begin
            released_reg <= 1'b1;
         end
         if (crc_error) begin
            crc_err_reg <= 1'b1;
         end
         done_oe <= !(released_reg || config_complete);
         delay_error_oe <= mode_sampled_reg && crc_err_reg;
         flash_select_n <= !cfg_active;
         flash_select_oe <= cfg_active;
         flash_output_enable_n <= !cfg_active;
         flash_output_enable_oe <= cfg_active;
         flash_write_enable_n <= 1'b1;
         flash_write_enable_oe <= cfg_active;
         // RQ10 pull-up select
         io_pullup_enable <= !pullup_s && !released_reg;
         // RQ14 reserve delay pin
         delay_pin_user_release <= (state_reg == nor_loader_pkg::st_finished) && !upset_en_reg;
      end
   end

   // register bus
   function automatic logic [1:0] ofs_resp(input logic [7:0] ofs);
      ofs_resp = (ofs == `CTRL_OFS || ofs == `LATENCY_OFS || ofs == `STATUS_OFS ||
                  ofs == `ADDR_OFS || ofs == `SAMPLE_OFS) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
   endfunction : ofs_resp

   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic w_lane0_reg;
   logic wr_fire;
   logic rd_fire;
   nor_loader_pkg::status_type status_word;
   logic [31:0] rd_word;

   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign status_word = '{state: state_reg, done_pin: done_s, wide: wide_reg,
                          width_known: width_known_reg, crc_error: crc_err_reg,
                          released: released_reg, mode: mode_reg};
   assign rd_word = (s_axi_araddr == `CTRL_OFS) ? {31'h00000000, upset_en_reg} :
                    (s_axi_araddr == `LATENCY_OFS) ? {24'h000000, latency_reg} :
                    (s_axi_araddr == `STATUS_OFS) ? {22'h000000, status_word} :
                    (s_axi_araddr == `ADDR_OFS) ? {6'h00, flash_addr} :
                    (s_axi_araddr == `SAMPLE_OFS) ? {16'h0000, sample_reg} : 32'h00000000;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_lane0_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_RESP_OKAY;
         upset_en_reg <= 1'b0;
         latency_reg <= `LATENCY_RESET;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_lane0_reg <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ofs_resp(aw_addr_reg);
            if (w_lane0_reg && aw_addr_reg == `CTRL_OFS) begin
               upset_en_reg <= w_data_reg[`CTRL_UPSET_BIT];
            end
            if (w_lane0_reg && aw_addr_reg == `LATENCY_OFS) begin
               latency_reg <= w_data_reg[7:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= ofs_resp(s_axi_araddr);
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : parallel_nor_config_reader

// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stage1_reg <= '0;
         q <= '0;
      end else if (clk_en) begin
         stage1_reg <= d;
         q <= stage1_reg;
      end
   end
endmodule : pin_sync

// file: tb/nor_flash_model.sv
`timescale 1ns/1ps
`include "nor_loader_map.svh"
module nor_flash_model (
   input wire logic mclk,
   input wire logic byte_mode,
   input wire logic [`FLASH_ADDR_W-1:0] flash_addr,
   input wire logic flash_select_n,
   input wire logic flash_select_oe,
   input wire logic flash_output_enable_n,
   input wire logic flash_output_enable_oe,
   output logic [`FLASH_DATA_W-1:0] flash_data
);
   logic read_on;
   logic [7:0] lo_byte;
   assign read_on = flash_select_oe && !flash_select_n && flash_output_enable_oe
      && !flash_output_enable_n;
   assign lo_byte = (flash_addr == '0) ? `SYNC_HI_BYTE :
      (flash_addr == 26'h0000001) ? `SYNC_LO_BYTE : (flash_addr[7:0] ^ 8'h3C);
   initial flash_data = 16'h0000;
   // one mclk of access time; a released bus keeps changing so stale data never passes
   always @(posedge mclk) begin
      if (!read_on) begin
         flash_data <= ~flash_data;
      end else if (byte_mode) begin
         flash_data <= {~lo_byte, lo_byte};
      end else if (flash_addr == '0) begin
         flash_data <= `SYNC_WORD;
      end else begin
         flash_data <= {~flash_addr[7:0], flash_addr[7:0]};
      end
   end
endmodule : nor_flash_model

// file: tb/parallel_nor_config_reader_sva.sv
`timescale 1ns/1ps
`include "nor_loader_map.svh"
module nor_loader_checker (
   input wire logic mclk,
   input wire logic reset,
   input wire logic restart_n,
   input wire logic clk_en,
   input wire logic [1:0] mode_pins,
   input wire logic config_pullup_control,
   input wire logic delay_error_in,
   input wire logic delay_error_oe,
   input wire logic done_in,
   input wire logic done_oe,
   input wire logic config_clock_out,
   input wire logic [`FLASH_ADDR_W-1:0] flash_addr,
   input wire logic flash_select_n,
   input wire logic flash_select_oe,
   input wire logic flash_output_enable_n,
   input wire logic flash_output_enable_oe,
   input wire logic flash_write_enable_n,
   input wire logic flash_write_enable_oe,
   input wire logic config_complete,
   input wire logic crc_error,
   input wire nor_loader_pkg::stream_word_type stream_word,
   input wire logic io_pullup_enable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || !restart_n);
   a_addr_step: assert property (
      $changed(flash_addr) |-> flash_addr == $past(flash_addr) + 1'b1 || flash_addr == '0)
      else $error("address stepped out of sequence");
   a_addr_on_fall: assert property (
      $changed(flash_addr) |-> $fell(config_clock_out))
      else $error("address moved off the falling clock edge");
   a_one_step: assert property (
      $changed(flash_addr) |=> $stable(flash_addr) [*3])
      else $error("address moved twice in one clock period");
   a_strobe_levels: assert property (
      flash_select_oe |-> !flash_select_n && flash_output_enable_oe && !flash_output_enable_n
         && flash_write_enable_oe && flash_write_enable_n)
      else $error("flash strobes wrong while loading");
   a_config_clock_out_loading: assert property (
      $rose(config_clock_out) |-> flash_select_oe)
      else $error("configuration clock runs while idle");
   a_done_release: assert property (
      config_complete && clk_en |=> !done_oe [*4])
      else $error("completion pin not released");
   a_stop_done: assert property (
      done_in [*5] |-> !stream_word.valid && !flash_select_oe)
      else $error("reading goes on after completion");
   a_crc_flag: assert property (
      crc_error && clk_en && flash_select_oe |-> ##2 delay_error_oe [*8])
      else $error("crc error not flagged on delay pin");
   a_pullup_off: assert property (
      config_pullup_control [*4] |-> !io_pullup_enable)
      else $error("pull-ups on with control pin high");
   a_delay_gate: assert property (
      $rose(flash_select_oe) |-> delay_error_in && $past(delay_error_in) && mode_pins == 2'h0)
      else $error("loading began while held off or in wrong mode");
   a_byte_upper: assert property (
      stream_word.valid && !stream_word.wide |-> stream_word.data[15:8] == 8'h00)
      else $error("byte-wide sample has upper bits set");
   c_done: cover property ($fell(done_oe));
   c_wide: cover property (stream_word.valid && stream_word.wide);
   c_narrow: cover property (stream_word.valid && !stream_word.wide);
   c_crc: cover property ($rose(delay_error_oe));
endmodule : nor_loader_checker

bind parallel_nor_config_reader nor_loader_checker u_chk (.*);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic restart_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [1:0] mode_pins = 2'h0;
   logic config_pullup_control = 1'b0, delay_hold = 1'b1, byte_mode = 1'b0;
   logic config_complete = 1'b0, crc_error = 1'b0;
   logic delay_error_in, delay_error_oe, done_in, done_oe, config_clock_out;
   logic [25:0] flash_addr;
   logic [15:0] flash_data;
   logic flash_select_n, flash_select_oe, flash_output_enable_n, flash_output_enable_oe;
   logic flash_write_enable_n, flash_write_enable_oe, io_pullup_enable, delay_pin_user_release;
   nor_loader_pkg::stream_word_type stream_word;
   int n_errors = 0;
   int checks_done = 0;
   always #10 mclk = ~mclk;
   // open-drain delay pin held low by the board
   assign delay_error_in = !(delay_hold || delay_error_oe);
   assign done_in = !done_oe;
   parallel_nor_config_reader #(.CONFIG_CLOCK_OUT_HALF(4)) u_dut (.*, .s_axi_wstrb(4'hF),
      .delay_error_out(), .done_out(), .flash_data_in(flash_data));
   nor_flash_model u_flash (.*);

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic hang(input int n);
      if (n >= 3000) begin
         chk(1'b0, "wait ran out");
         end_sim();
      end
   endtask : hang

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 3000; n++) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      hang(n);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp === er, "write response");
      @(posedge mclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 3000; n++) begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      hang(n);
      s_axi_rready <= 1'b0;
      chk((s_axi_rdata & m) === e && s_axi_rresp === er, "read value or response");
      @(posedge mclk);
   endtask : axi_rd

   // counts clock rises seen while address zero is still presented, header sample included
   task automatic load_start(output int rises);
      int n;
      logic prev;
      for (n = 0; n < 3000 && flash_select_oe !== 1'b1; n++) @(posedge mclk);
      hang(n);
      rises = 0;
      prev = config_clock_out;
      for (n = 0; n < 3000 && flash_addr === '0; n++) begin
         @(posedge mclk);
         if (config_clock_out === 1'b1 && prev === 1'b0 && flash_addr === '0) rises++;
         prev = config_clock_out;
      end
      hang(n);
   endtask : load_start

   task automatic expect_words(input logic wide, input int first, input int cnt);
      int n;
      logic [7:0] k;
      for (int i = 0; i < cnt; i++) begin
         for (n = 0; n < 3000 && stream_word.valid !== 1'b1; n++) @(posedge mclk);
         hang(n);
         k = 8'(first + i);
         chk(stream_word.wide === wide && stream_word.data === (wide ? {~k, k} : {8'h00, k ^ 8'h3C}),
            "stream sample");
         @(posedge mclk);
      end
   endtask : expect_words

   task automatic t_idle_regs;
      axi_rd(8'h00, 32'hFFFFFFFF, 32'h00000000, 2'h0);
      axi_rd(8'h04, 32'h000000FF, 32'h00000008, 2'h0);
      // held off in the waiting state
      axi_rd(8'h08, 32'h00000380, 32'h00000000, 2'h0);
      axi_rd(8'h40, 32'hFFFFFFFF, 32'h00000000, 2'h2);
      axi_wr(8'h40, 32'h00000001, 2'h2);
      axi_wr(8'h04, 32'h00000001, 2'h0);
      axi_wr(8'h00, 32'h00000001, 2'h0);
      axi_rd(8'h04, 32'hFFFFFFFF, 32'h00000001, 2'h0);
      axi_rd(8'h00, 32'hFFFFFFFF, 32'h00000001, 2'h0);
      chk(flash_select_oe === 1'b0 && config_clock_out === 1'b0, "load not postponed");
      chk(io_pullup_enable === 1'b1 && done_oe === 1'b1, "idle pin levels");
      $display("idle and registers done");
   endtask : t_idle_regs

   task automatic t_load_wide;
      int rises;
      delay_hold <= 1'b0;
      load_start(rises);
      chk(flash_select_n === 1'b0 && flash_output_enable_n === 1'b0, "read strobes");
      chk(flash_write_enable_n === 1'b1 && flash_write_enable_oe === 1'b1, "write strobe");
      chk(rises === 2, "first address hold");
      expect_words(1'b1, 1, 5);
      chk(delay_error_oe === 1'b0, "delay pin flags error too early");
      config_pullup_control <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(io_pullup_enable === 1'b0, "pull-ups not off");
      config_pullup_control <= 1'b0;
      $display("wide load done");
   endtask : t_load_wide

   task automatic t_finish(input logic upset_on);
      logic [25:0] held;
      crc_error <= upset_on;
      config_complete <= 1'b1;
      @(posedge mclk);
      crc_error <= 1'b0;
      config_complete <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(done_oe === 1'b0, "completion pin kept low");
      chk(delay_error_oe === upset_on, "crc error on delay pin");
      repeat (10) @(posedge mclk);
      held = flash_addr;
      chk(flash_select_oe === 1'b0 && flash_output_enable_oe === 1'b0, "strobes kept");
      chk(flash_write_enable_oe === 1'b0 && config_clock_out === 1'b0, "clock or write kept");
      repeat (100) @(posedge mclk);
      chk(flash_addr === held && stream_word.valid === 1'b0, "reading went on");
      chk(delay_pin_user_release === !upset_on, "delay pin release");
      $display("finish done");
   endtask : t_finish

   task automatic t_restart_narrow;
      int rises;
      restart_n <= 1'b0;
      #5;
      chk(done_oe === 1'b1 && flash_select_oe === 1'b0, "restart not immediate");
      byte_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      restart_n <= 1'b1;
      load_start(rises);
      chk(rises === 9, "default first address hold");
      expect_words(1'b0, 2, 4);
      axi_rd(8'h00, 32'hFFFFFFFF, 32'h00000000, 2'h0);
      t_finish(1'b0);
      $display("narrow load done");
   endtask : t_restart_narrow

   task automatic t_other_mode;
      reset <= 1'b1;
      mode_pins <= 2'h1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      repeat (300) @(posedge mclk);
      chk(flash_select_oe === 1'b0 && config_clock_out === 1'b0, "loaded in other mode");
      axi_rd(8'h08, 32'h00000380, 32'h00000280, 2'h0);
      $display("other mode done");
   endtask : t_other_mode

   initial begin
      // restart held with reset until the flash is up
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      restart_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_idle_regs();
      t_load_wide();
      t_finish(1'b1);
      t_restart_narrow();
      t_other_mode();
      end_sim();
   end
endmodule : tb
